// *** rtl/dual_timer_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // pins
    input wire logic ext_irq_pin_a_in,
    input wire logic ext_irq_pin_b_in,
    input wire logic first_count_input_pin_in,
    input wire logic second_count_input_pin_in,
    output logic overflow_div64_output_pin_out,
    // interrupt controller
    input wire logic first_timer_vector_ack_in,
    input wire logic second_timer_vector_ack_in,
    output logic first_timer_overflow_flag_out,
    output logic second_timer_overflow_flag_out
);
    import timer_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [0:0] tick_count_q;
    logic [0:0] tick_count_d;
    logic tick;
    logic [7:0] timer_run_and_flags_q;
    logic [7:0] timer_run_and_flags_d;
    logic [7:0] timer_mode_select_q;
    logic [7:0] timer_mode_select_d;
    timer_count_t first_count_q;
    timer_count_t first_count_d;
    timer_count_t second_count_q;
    timer_count_t second_count_d;
    bus_access_t write_q;
    bus_access_t write_d;
    bus_access_t read_q;
    bus_access_t read_d;
    logic ready_q;
    logic ready_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // ------------------------------------------------------------
    // decoded controls and steps
    // ------------------------------------------------------------
    timer_ctrl_t first_ctrl;
    timer_ctrl_t second_ctrl;
    logic first_timer_run;
    logic second_timer_run;
    logic first_step;
    logic second_step;
    logic split_high_step;
    logic first_overflow;
    logic second_overflow;
    logic split_overflow;
    timer_step_t first_result;
    timer_step_t second_result;
    logic address_phase;
    logic [7:0] addr_index;
    logic addr_mapped;
    logic [7:0] wr_byte;

    // ------------------------------------------------------------
    // counting structure shared by both timers
    // ------------------------------------------------------------
    function automatic timer_step_t count_step(
        input timer_mode_t mode,
        input logic step,
        input timer_count_t cnt
    );
        timer_step_t r;
        r.count = cnt;
        r.overflow = 1'b0;
        if (step) begin
            unique case (mode)
                MODE_PRESCALED: begin
                    if (cnt.low[4:0] == PRESCALE_LAST) begin
                        r.count.low[4:0] = 5'h00;
                        r.count.high = cnt.high + 8'h01;
                        r.overflow = (cnt.high == 8'hFF);
                    end else begin
                        r.count.low[4:0] = cnt.low[4:0] + 5'h01;
                    end
                end
                MODE_FULL: begin
                    {r.overflow, r.count} = {1'b0, cnt} + 17'h00001;
                end
                MODE_RELOAD: begin
                    r.count.low = cnt.low + 8'h01;
                    if (cnt.low == 8'hFF) begin
                        r.count.low = cnt.high;
                        r.overflow = 1'b1;
                    end
                end
                MODE_SPLIT: begin
                    {r.overflow, r.count.low} = {1'b0, cnt.low} + 9'h001;
                end
            endcase
        end
        return r;
    endfunction : count_step

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    always_comb begin
        tick = (tick_count_q == TICK_LAST);
        tick_count_d = tick ? 1'b0 : tick_count_q + 1'b1;
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tick_count_q <= 1'b0;
        end else begin
            tick_count_q <= tick_count_d;
        end
    end

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    always_comb begin
        first_ctrl = timer_ctrl_t'(timer_mode_select_q[3:0]);
        second_ctrl = timer_ctrl_t'(timer_mode_select_q[7:4]);
        first_timer_run = timer_run_and_flags_q[FIRST_RUN_BIT];
        second_timer_run = timer_run_and_flags_q[SECOND_RUN_BIT];
    end

    count_enable first_enable (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .tick_in(tick),
        .run_in(first_timer_run),
        .gating_in(first_ctrl.pin_gating),
        .gate_pin_in(ext_irq_pin_a_in),
        .source_select_in(first_ctrl.source_select),
        .count_pin_in(first_count_input_pin_in),
        .step_out(first_step)
    );

    count_enable second_enable (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .tick_in(tick),
        .run_in(second_timer_run),
        .gating_in(second_ctrl.pin_gating),
        .gate_pin_in(ext_irq_pin_b_in),
        .source_select_in(second_ctrl.source_select),
        .count_pin_in(second_count_input_pin_in),
        .step_out(second_step)
    );

    // the borrowed high byte runs on the time base while the second run bit is set, ungated
    count_enable split_enable (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .tick_in(tick),
        .run_in(second_timer_run),
        .gating_in(1'b0),
        .gate_pin_in(1'b1),
        .source_select_in(1'b0),
        .count_pin_in(1'b0),
        .step_out(split_high_step)
    );

    overflow_divider div64 (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .overflow_in(first_overflow),
        .divided_out(overflow_div64_output_pin_out)
    );

    // ------------------------------------------------------------
    // counters and flags
    // ------------------------------------------------------------
    always_comb begin
        wr_byte = hwdata_in[7:0];
        // step sources come from the enables above
        first_result = count_step(first_ctrl.mode, first_step, first_count_q);
        // mode 11 on the second timer simply withholds its steps
        second_result = count_step(second_ctrl.mode,
            second_step & (second_ctrl.mode != MODE_SPLIT), second_count_q);
        first_count_d = first_result.count;
        second_count_d = second_result.count;
        first_overflow = first_result.overflow;
        split_overflow = 1'b0;
        if (first_ctrl.mode == MODE_SPLIT && split_high_step) begin
            {split_overflow, first_count_d.high} = {1'b0, first_count_q.high} + 9'h001;
        end
        // while split, the second timer keeps counting but its flag is lent out
        second_overflow = (first_ctrl.mode == MODE_SPLIT) ? split_overflow
                                                          : second_result.overflow;

        timer_run_and_flags_d = timer_run_and_flags_q;
        timer_mode_select_d = timer_mode_select_q;
        if (write_q.pending && write_q.mapped) begin
            unique case (write_q.index)
                RUN_FLAGS_IDX: timer_run_and_flags_d = wr_byte;
                MODE_SELECT_IDX: timer_mode_select_d = wr_byte;
                FIRST_LOW_IDX: first_count_d.low = wr_byte;
                FIRST_HIGH_IDX: first_count_d.high = wr_byte;
                SECOND_LOW_IDX: second_count_d.low = wr_byte;
                SECOND_HIGH_IDX: second_count_d.high = wr_byte;
                default: begin
                end
            endcase
        end
        if (first_timer_vector_ack_in) begin
            timer_run_and_flags_d[FIRST_FLAG_BIT] = 1'b0;
        end
        if (second_timer_vector_ack_in) begin
            timer_run_and_flags_d[SECOND_FLAG_BIT] = 1'b0;
        end
        // a new overflow beats any clear in the same cycle
        if (first_overflow) begin
            timer_run_and_flags_d[FIRST_FLAG_BIT] = 1'b1;
        end
        if (second_overflow) begin
            timer_run_and_flags_d[SECOND_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            timer_run_and_flags_q <= RUN_FLAGS_RESET;
            timer_mode_select_q <= MODE_SELECT_RESET;
            first_count_q <= {COUNT_RESET, COUNT_RESET};
            second_count_q <= {COUNT_RESET, COUNT_RESET};
        end else begin
            timer_run_and_flags_q <= timer_run_and_flags_d;
            timer_mode_select_q <= timer_mode_select_d;
            first_count_q <= first_count_d;
            second_count_q <= second_count_d;
        end
    end

    assign first_timer_overflow_flag_out = timer_run_and_flags_q[FIRST_FLAG_BIT];
    assign second_timer_overflow_flag_out = timer_run_and_flags_q[SECOND_FLAG_BIT];

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    // reads take one wait state so the returned word comes from a flop
    // and already reflects a write in the directly preceding transfer
    always_comb begin
        address_phase = hsel_in & hready_in & (htrans_in[1] != HTRANS_IDLE[1]);
        addr_index = haddr_in[9:2];
        addr_mapped = (haddr_in[31:10] == 22'h000000) &&
                      (addr_index >= RUN_FLAGS_IDX) && (addr_index <= SECOND_HIGH_IDX);
        write_d = '0;
        read_d = '0;
        ready_d = ready_q;
        rdata_d = rdata_q;
        if (address_phase) begin
            if (hwrite_in) begin
                write_d = '{pending: 1'b1, mapped: addr_mapped, index: addr_index};
            end else begin
                read_d = '{pending: 1'b1, mapped: addr_mapped, index: addr_index};
                ready_d = 1'b0;
            end
        end
        if (read_q.pending) begin
            ready_d = 1'b1;
            rdata_d = READ_ZERO;
            if (read_q.mapped) begin
                unique case (read_q.index)
                    RUN_FLAGS_IDX: rdata_d[7:0] = timer_run_and_flags_q;
                    MODE_SELECT_IDX: rdata_d[7:0] = timer_mode_select_q;
                    FIRST_LOW_IDX: rdata_d[7:0] = first_count_q.low;
                    FIRST_HIGH_IDX: rdata_d[7:0] = first_count_q.high;
                    SECOND_LOW_IDX: rdata_d[7:0] = second_count_q.low;
                    SECOND_HIGH_IDX: rdata_d[7:0] = second_count_q.high;
                    default: rdata_d = READ_ZERO;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            write_q <= '0;
            read_q <= '0;
            ready_q <= 1'b1;
            rdata_q <= READ_ZERO;
        end else begin
            write_q <= write_d;
            read_q <= read_d;
            ready_q <= ready_d;
            rdata_q <= rdata_d;
        end
    end

    assign hrdata_out = rdata_q;
    assign hreadyout_out = ready_q;
    assign hresp_out = HRESP_OKAY;

endmodule : dual_timer_counter
`default_nettype wire

// *** rtl/timer_pkg.sv ***
package timer_pkg;

    // ------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0] RUN_FLAGS_IDX = 8'h88;
    localparam logic [7:0] MODE_SELECT_IDX = 8'h89;
    localparam logic [7:0] FIRST_LOW_IDX = 8'h8A;
    localparam logic [7:0] FIRST_HIGH_IDX = 8'h8B;
    localparam logic [7:0] SECOND_LOW_IDX = 8'h8C;
    localparam logic [7:0] SECOND_HIGH_IDX = 8'h8D;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int SECOND_FLAG_BIT = 7;
    localparam int SECOND_RUN_BIT = 6;
    localparam int FIRST_FLAG_BIT = 5;
    localparam int FIRST_RUN_BIT = 4;
    localparam logic [7:0] RUN_FLAGS_RESET = 8'h00;
    localparam logic [7:0] MODE_SELECT_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_PERIOD_CYCLES = 2;
    localparam logic [0:0] TICK_LAST = 1'(TICK_PERIOD_CYCLES - 1);
    localparam int DIV_RATIO = 64;
    localparam logic [4:0] DIV_HALF_LAST = 5'((DIV_RATIO / 2) - 1);
    localparam logic [4:0] PRESCALE_LAST = 5'h1F;

    // ------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_PRESCALED = 2'b00,
        MODE_FULL = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } timer_mode_t;

    typedef struct packed {
        logic pin_gating;
        logic source_select;
        timer_mode_t mode;
    } timer_ctrl_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } timer_count_t;

    typedef struct packed {
        logic overflow;
        timer_count_t count;
    } timer_step_t;

    typedef struct packed {
        logic pending;
        logic mapped;
        logic [7:0] index;
    } bus_access_t;

endpackage : timer_pkg

// *** rtl/count_enable.sv ***
`timescale 1ns/1ps
`default_nettype none
module count_enable (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // controls
    input wire logic tick_in,
    input wire logic run_in,
    input wire logic gating_in,
    input wire logic gate_pin_in,
    input wire logic source_select_in,
    input wire logic count_pin_in,
    // step request
    output logic step_out
);
    import timer_pkg::*;

    logic pin_prev_q;
    logic pin_prev_d;
    logic enabled;
    logic source;

    // the pin is looked at only on the time base, so a pulse shorter
    // than two clocks can fall between samples
    always_comb begin
        pin_prev_d = tick_in ? count_pin_in : pin_prev_q;
        enabled = run_in & (~gating_in | gate_pin_in);
        source = source_select_in ? (tick_in & pin_prev_q & ~count_pin_in) : tick_in;
        step_out = enabled & source;
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_prev_d;
        end
    end

endmodule : count_enable
`default_nettype wire

// *** rtl/overflow_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module overflow_divider (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // overflow events
    input wire logic overflow_in,
    // divided square wave
    output logic divided_out
);
    import timer_pkg::*;

    logic [4:0] count_q;
    logic [4:0] count_d;
    logic level_q;
    logic level_d;

    // toggling every half ratio gives one full period per DIV_RATIO events
    always_comb begin
        count_d = count_q;
        level_d = level_q;
        if (overflow_in) begin
            if (count_q == DIV_HALF_LAST) begin
                count_d = 5'h00;
                level_d = ~level_q;
            end else begin
                count_d = count_q + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            count_q <= 5'h00;
            level_q <= 1'b0;
        end else begin
            count_q <= count_d;
            level_q <= level_d;
        end
    end

    assign divided_out = level_q;

endmodule : overflow_divider
`default_nettype wire

// *** sim/dual_timer_counter_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_chk (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // bus
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    // interrupt controller
    input wire logic first_timer_vector_ack_in,
    input wire logic second_timer_vector_ack_in,
    input wire logic first_timer_overflow_flag_out,
    input wire logic second_timer_overflow_flag_out
);
    import timer_pkg::*;
    logic taken;
    logic wr_q;
    assign taken = hsel_in && hready_in && htrans_in[1];
    // a write data phase is the only software path that may drop a flag
    always_ff @(posedge core_clk_in) begin
        if (rst_in) wr_q <= 1'b0;
        else if (hready_in) wr_q <= taken && hwrite_in;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    a_read_one_wait: assert property (taken && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (taken && hwrite_in |=> hreadyout_out)
        else $error("write stalled");
    a_ready_low_one: assert property (!hreadyout_out |=> hreadyout_out)
        else $error("ready low too long");
    a_rdata_hold: assert property ($changed(hrdata_out) |-> $rose(hreadyout_out))
        else $error("read data moved outside a read");
    a_rdata_upper: assert property (hrdata_out[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_resp_okay: assert property (hresp_out == HRESP_OKAY)
        else $error("response not okay");
    a_flag0_clear: assert property ($fell(first_timer_overflow_flag_out)
        |-> $past(first_timer_vector_ack_in) || $past(wr_q))
        else $error("first flag dropped without cause");
    a_flag1_clear: assert property ($fell(second_timer_overflow_flag_out)
        |-> $past(second_timer_vector_ack_in) || $past(wr_q))
        else $error("second flag dropped without cause");
endmodule : dual_timer_counter_chk
bind dual_timer_counter dual_timer_counter_chk chk (
    .core_clk_in,
    .rst_in,
    .hsel_in,
    .htrans_in,
    .hwrite_in,
    .hready_in,
    .hrdata_out,
    .hreadyout_out,
    .hresp_out,
    .first_timer_vector_ack_in,
    .second_timer_vector_ack_in,
    .first_timer_overflow_flag_out,
    .second_timer_overflow_flag_out
);
`default_nettype wire

// *** sim/pin_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    // clock
    input wire logic core_clk_in,
    // requests from the bench
    input wire logic [1:0] fire_in,
    input wire logic [1:0] gate_level_in,
    // pins toward the timer block
    output logic ext_irq_pin_a_out,
    output logic ext_irq_pin_b_out,
    output logic first_count_input_pin_out,
    output logic second_count_input_pin_out
);
    logic [2:0] low_a_q = 3'h0;
    logic [2:0] low_b_q = 3'h0;
    // four clocks low: spans a time base sample
    always_ff @(posedge core_clk_in) begin
        low_a_q <= fire_in[0] ? 3'h4 : low_a_q - 3'(low_a_q != 3'h0);
        low_b_q <= fire_in[1] ? 3'h4 : low_b_q - 3'(low_b_q != 3'h0);
    end
    assign first_count_input_pin_out = (low_a_q == 3'h0);
    assign second_count_input_pin_out = (low_b_q == 3'h0);
    assign ext_irq_pin_a_out = gate_level_in[0];
    assign ext_irq_pin_b_out = gate_level_in[1];
endmodule : pin_partner
`default_nettype wire

// *** sim/dual_timer_counter_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_tb;
    import timer_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsel_in = 1'b0;
    logic [31:0] haddr_in = 32'h0;
    logic [1:0] htrans_in = HTRANS_IDLE;
    logic hwrite_in = 1'b0;
    logic [31:0] hwdata_in = 32'h0;
    logic first_timer_vector_ack_in = 1'b0;
    logic second_timer_vector_ack_in = 1'b0;
    logic [1:0] fire = 2'b00;
    logic [1:0] gate_level = 2'b00;
    logic [31:0] hrdata_out;
    logic hreadyout_out, hresp_out, overflow_div64_output_pin_out;
    logic first_timer_overflow_flag_out, second_timer_overflow_flag_out;
    logic ext_irq_pin_a_in, ext_irq_pin_b_in;
    logic first_count_input_pin_in, second_count_input_pin_in;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;

    dual_timer_counter dut (.core_clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in,
        .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hrdata_out,
        .hreadyout_out, .hresp_out, .ext_irq_pin_a_in, .ext_irq_pin_b_in,
        .first_count_input_pin_in, .second_count_input_pin_in,
        .overflow_div64_output_pin_out, .first_timer_vector_ack_in,
        .second_timer_vector_ack_in, .first_timer_overflow_flag_out,
        .second_timer_overflow_flag_out);
    pin_partner far_side (.core_clk_in, .fire_in(fire), .gate_level_in(gate_level),
        .ext_irq_pin_a_out(ext_irq_pin_a_in), .ext_irq_pin_b_out(ext_irq_pin_b_in),
        .first_count_input_pin_out(first_count_input_pin_in),
        .second_count_input_pin_out(second_count_input_pin_in));

    always #(CLK_PERIOD_NS / 2) core_clk_in = ~core_clk_in;

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic do_reset();
        rst_in <= 1'b1;
        repeat (12) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : do_reset

    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        hsel_in <= 1'b1;
        htrans_in <= 2'b10;
        hwrite_in <= w;
        haddr_in <= {22'h0, idx, 2'b00};
        @(posedge core_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge core_clk_in);
        htrans_in <= HTRANS_IDLE;
        hwdata_in <= {24'h0, wd};
        @(posedge core_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge core_clk_in);
        rd = hrdata_out[7:0];
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        logic [7:0] unused;
        xfer(1'b1, idx, val, unused);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        xfer(1'b0, idx, 8'h00, v);
        check(what, v, exp);
    endtask : rd_chk

    // k clocks of counting from the run write (k+2 if the run bit was already set), then gated off
    task automatic run_span(input logic [7:0] run, input logic [7:0] mode, input int k);
        wr(MODE_SELECT_IDX, mode);
        wr(RUN_FLAGS_IDX, run);
        repeat (k - 2) @(posedge core_clk_in);
        wr(MODE_SELECT_IDX, mode | 8'h88);
    endtask : run_span

    task automatic ack_pulse(input int which);
        if (which == 0) first_timer_vector_ack_in <= 1'b1;
        else second_timer_vector_ack_in <= 1'b1;
        @(posedge core_clk_in);
        first_timer_vector_ack_in <= 1'b0;
        second_timer_vector_ack_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : ack_pulse

    task automatic pulses(input int n);
        repeat (n) begin
            fire <= 2'b11;
            @(posedge core_clk_in);
            fire <= 2'b00;
            repeat (12) @(posedge core_clk_in);
        end
    endtask : pulses

    task automatic set_counts(input logic [7:0] lo, input logic [7:0] hi, input int t);
        wr(t ? SECOND_LOW_IDX : FIRST_LOW_IDX, lo);
        wr(t ? SECOND_HIGH_IDX : FIRST_HIGH_IDX, hi);
    endtask : set_counts

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd_chk("run reset", RUN_FLAGS_IDX, RUN_FLAGS_RESET);
        rd_chk("mode reset", MODE_SELECT_IDX, MODE_SELECT_RESET);
        wr(8'h90, 8'h5A);
        rd_chk("unmapped", 8'h90, 8'h00);
        wr(RUN_FLAGS_IDX, 8'h0F);
        rd_chk("run low nibble", RUN_FLAGS_IDX, 8'h0F);
        for (int i = 0; i < 4; i++) wr(FIRST_LOW_IDX + 8'(i), 8'hA5 ^ 8'(i));
        for (int i = 0; i < 4; i++) rd_chk("count byte", FIRST_LOW_IDX + 8'(i), 8'hA5 ^ 8'(i));
        wr(RUN_FLAGS_IDX, 8'h00);
    endtask : t_regs

    task automatic t_timebase();
        set_counts(8'hF0, 8'h00, 0);
        run_span(8'h10, 8'h01, 100);
        wr(RUN_FLAGS_IDX, 8'h00);
        wr(MODE_SELECT_IDX, 8'h01);
        repeat (20) @(posedge core_clk_in);
        rd_chk("t0 low", FIRST_LOW_IDX, 8'h22);
        rd_chk("t0 high", FIRST_HIGH_IDX, 8'h01);
    endtask : t_timebase

    task automatic t_reload();
        set_counts(8'hFE, 8'hF0, 0);
        run_span(8'h10, 8'h02, 100);
        rd_chk("t0 reload low", FIRST_LOW_IDX, 8'hF0);
        rd_chk("t0 reload high", FIRST_HIGH_IDX, 8'hF0);
        check("flag0 set", 8'(first_timer_overflow_flag_out), 8'h01);
        wr(RUN_FLAGS_IDX, 8'h20);
        ack_pulse(0);
        check("flag0 ack", 8'(first_timer_overflow_flag_out), 8'h00);
    endtask : t_reload

    task automatic t_prescale();
        set_counts(8'hFE, 8'hFF, 0);
        run_span(8'h10, 8'h00, 4);
        rd_chk("t0 pre low", FIRST_LOW_IDX, 8'hE0);
        rd_chk("t0 pre high", FIRST_HIGH_IDX, 8'h00);
        check("flag0 wrap", 8'(first_timer_overflow_flag_out), 8'h01);
        wr(RUN_FLAGS_IDX, 8'h00);
        @(posedge core_clk_in);
        check("flag0 write", 8'(first_timer_overflow_flag_out), 8'h00);
    endtask : t_prescale

    task automatic t_second();
        set_counts(8'hFE, 8'hFF, 1);
        run_span(8'h40, 8'h10, 100);
        rd_chk("t1 low", SECOND_LOW_IDX, 8'h30);
        rd_chk("t1 high", SECOND_HIGH_IDX, 8'h00);
        check("flag1 set", 8'(second_timer_overflow_flag_out), 8'h01);
        ack_pulse(1);
        check("flag1 ack", 8'(second_timer_overflow_flag_out), 8'h00);
        run_span(8'h40, 8'h30, 100);
        rd_chk("t1 mode 11", SECOND_LOW_IDX, 8'h30);
        set_counts(8'hFF, 8'hC3, 1);
        run_span(8'h40, 8'h20, 2);
        rd_chk("t1 reload", SECOND_LOW_IDX, 8'hC4);
        wr(RUN_FLAGS_IDX, 8'h00);
    endtask : t_second

    task automatic t_counter();
        set_counts(8'h00, 8'h00, 0);
        set_counts(8'h00, 8'h00, 1);
        gate_level <= 2'b01;
        wr(MODE_SELECT_IDX, 8'h5D);
        wr(RUN_FLAGS_IDX, 8'h50);
        pulses(3);
        gate_level <= 2'b00;
        repeat (12) @(posedge core_clk_in);
        pulses(2);
        wr(RUN_FLAGS_IDX, 8'h00);
        rd_chk("t0 pin count", FIRST_LOW_IDX, 8'h03);
        rd_chk("t1 pin count", SECOND_LOW_IDX, 8'h05);
    endtask : t_counter

    task automatic t_split();
        set_counts(8'hFF, 8'hFF, 0);
        run_span(8'h50, 8'h03, 2);
        rd_chk("split low", FIRST_LOW_IDX, 8'h00);
        check("split flag0", 8'(first_timer_overflow_flag_out), 8'h01);
        check("split flag1", 8'(second_timer_overflow_flag_out), 8'h01);
    endtask : t_split

    // reset again so the divider counts from zero
    task automatic t_div();
        do_reset();
        set_counts(8'hFF, 8'hFF, 0);
        run_span(8'h10, 8'h02, 62);
        repeat (4) @(posedge core_clk_in);
        check("div after 31", 8'(overflow_div64_output_pin_out), 8'h00);
        run_span(8'h10, 8'h02, 2);
        repeat (4) @(posedge core_clk_in);
        check("div after 33", 8'(overflow_div64_output_pin_out), 8'h01);
    endtask : t_div

    initial begin
        do_reset();
        t_regs();
        t_timebase();
        t_reload();
        t_prescale();
        t_second();
        t_counter();
        t_split();
        t_div();
        test_done();
    end
endmodule : dual_timer_counter_tb
`default_nettype wire
